// ===== proc_rail_model.sv
// Behavioural processor and rail model behind the sequencer
`default_nettype none

module proc_rail_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_nrst,
    // Sequencer side
    input  wire logic i_proc_stop,
    input  wire logic i_slow,
    // Halt acknowledge
    output var logic  o_proc_stopped
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] lag_r;

    // halt acknowledged late
    // Slow halt makes the sequencer wait
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst || !i_proc_stop)
        begin
            lag_r          <= 4'h0;
            o_proc_stopped <= 1'b0;
        end
        else
        begin
            lag_r          <= lag_r + {3'h0, lag_r != 4'hf};
            o_proc_stopped <= lag_r >= (i_slow ? 4'h6 : 4'h0);
        end
    end
endmodule

`default_nettype wire

// ===== sleep_wake_checker_props.sv
// Port-level checks for the sleep and wake sequencer
`default_nettype none

module sleep_wake_checker #(
    parameter int OVR_COUNT = 20
) (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_nrst,
    // Register bus
    input wire logic [4:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic        o_avs_waitrequest,
    // Platform
    input wire logic        i_power_button,
    input wire logic        o_proc_stop,
    input wire logic        o_rails_low,
    input wire logic        o_cpu_reset,
    input wire logic [2:0]  o_sleep_type,
    input wire logic        o_power_button_override
);
    timeunit 1ns;
    timeprecision 1ps;

    int   hold_cnt_r;
    logic ctl_take;

    // Control write completing
    assign ctl_take = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h00;

    // Button hold length
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            hold_cnt_r <= 0;
        else
            hold_cnt_r <= i_power_button ? hold_cnt_r + 1 : 0;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // Trigger taken in working state, nonzero type
    sequence s_trigger;
        ctl_take && i_avs_byteenable[0] && i_avs_writedata[4] && i_avs_writedata[2:0] != 3'h0
            && !o_proc_stop && o_sleep_type == 3'h0 && !i_power_button;
    endsequence
    sequence s_shallow_exit;
        o_proc_stop && o_sleep_type == 3'h1 ##1 !o_proc_stop;
    endsequence
    sequence s_deep_exit;
        o_proc_stop && o_sleep_type >= 3'h2 ##1 !o_proc_stop;
    endsequence

    AST_BUS_ANSWER: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("Bus not answered");
    AST_BUS_ONE: assert property (
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("Bus answer too long");
    AST_TRIG_ENTER: assert property (
        s_trigger |-> ##2 o_proc_stop && o_sleep_type == $past(i_avs_writedata[2:0], 2))
        else $error("Trigger missed its type");
    AST_NO_SELF_SLEEP: assert property (
        !o_proc_stop && !ctl_take && !$past(ctl_take) |=> !o_proc_stop || o_power_button_override)
        else $error("Sleep without trigger");
    AST_OVR_HOLD: assert property (
        o_power_button_override |-> hold_cnt_r >= OVR_COUNT)
        else $error("Override too early");
    AST_OVR_OFF: assert property (
        o_power_button_override |-> o_proc_stop && o_rails_low && o_sleep_type == 3'h5
            ##1 !o_power_button_override)
        else $error("Override not one off step");
    AST_RAIL_TYPE: assert property (
        o_rails_low |-> o_proc_stop && o_sleep_type >= 3'h2)
        else $error("Rails low while awake");
    AST_DEEP_RESET: assert property (
        s_deep_exit |=> o_cpu_reset ##1 !o_cpu_reset)
        else $error("Deep wake without reset");
    AST_SHALLOW_RESUME: assert property (
        s_shallow_exit |=> !o_cpu_reset)
        else $error("Shallow wake reset");
    AST_RESET_CAUSE: assert property (
        o_cpu_reset |-> !o_proc_stop && $past(o_proc_stop, 2))
        else $error("Reset without sleep");
endmodule

bind sleep_wake_sequencer sleep_wake_checker #(.OVR_COUNT(OVR_COUNT)) u_checker (.*);

`default_nettype wire

// ===== sleep_wake_pkg.sv
// Constants, state codes and carrier types for the sleep and wake sequencer
`default_nettype none

package sleep_wake_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [4:0] OFF_CONTROL = 5'h00;
    localparam logic [4:0] OFF_STATUS  = 5'h04;
    localparam logic [4:0] OFF_ENABLE  = 5'h08;
    localparam logic [4:0] OFF_DAY     = 5'h0c;
    localparam logic [4:0] OFF_MONTH   = 5'h10;
    localparam logic [4:0] OFF_CENTURY = 5'h14;

    // Control word fields
    localparam int CTL_TYPE_LSB = 0;
    localparam int CTL_TRIG_BIT = 4;

    // Status word fields
    localparam int STS_WAKE_BIT  = 0;
    localparam int STS_PWRB_BIT  = 1;
    localparam int STS_ALARM_BIT = 2;
    localparam int STS_STATE_LSB = 4;
    localparam int STS_TYPE_LSB  = 8;

    // Enable word fields
    localparam int EN_ALARM_BIT  = 0;
    localparam int EN_DEEP_BIT   = 1;
    localparam int EN_EVENTS_LSB = 8;

    // Sleep type encodings
    localparam logic [2:0] TYPE_WORK = 3'h0;
    localparam logic [2:0] TYPE_S1   = 3'h1;
    localparam logic [2:0] TYPE_S2   = 3'h2;
    localparam logic [2:0] TYPE_S3   = 3'h3;
    localparam logic [2:0] TYPE_S4   = 3'h4;
    localparam logic [2:0] TYPE_S5   = 3'h5;

    // Legal alarm byte ranges
    localparam logic [7:0] DAY_BCD_MAX = 8'h31;
    localparam logic [7:0] DAY_BIN_MAX = 8'h1f;
    localparam logic [7:0] MON_BCD_MAX = 8'h12;
    localparam logic [7:0] MON_BIN_MAX = 8'h0c;
    localparam logic [7:0] DAY_FIELD_MASK = 8'h3f;

    // Reset values
    localparam logic [7:0] RST_ALARM_BYTE = 8'hff;
    localparam logic [7:0] RST_CENTURY    = 8'h20;

    // Override hold time
    localparam int CLK_HZ        = 50_000_000;
    localparam int OVR_TIME_S    = 4;
    localparam int OVR_CYCLES    = OVR_TIME_S * CLK_HZ;

    // Sequencer states, gray along work-enter-sleep-wake
    typedef enum logic [2:0] {
        ST_WORK  = 3'b000,
        ST_ENTER = 3'b001,
        ST_SLEEP = 3'b011,
        ST_WAKE  = 3'b010,
        ST_OFF   = 3'b110
    } seq_state_t;

    // Extended alarm bytes, kept in bank 0 of the clock storage
    typedef struct packed {
        logic [7:0] century;
        logic [7:0] month;
        logic [7:0] day;
    } alarm_bytes_t;

endpackage

`default_nettype wire

// ===== sleep_wake_sequencer.sv
// Sleep and wake sequencer with clock alarm wake and power button override
`default_nettype none

// Overview of operation
// R1: Trigger sequences into programmed sleep type
// R2: Software loads sleep type before trigger
// R3: Button held over 4 s forces off
// R4: Override clears power button flag
// R5: Enabled wake event returns sleep to working
// R6: Wake accepted once processor stopped; sets flag
// R7: Software polls wake flag after shallow sleep
// R8: Shallow wake resumes; deeper wake resets processor
// R9: No shallow state means wake flag zero
// R10: Resleep by wake, reprogram, retrigger
// R11: Alarm wakes S1-S3; S4 when flagged
// R12: Every alarm sets alarm flag
// R13: Flag and enable wake unless battery low
// R14: Alarm flag fed by clock interrupt line
// R15: Day alarm ignores bits 6 and 7
// R16: Illegal day byte gives daily alarm
// R17: Illegal month byte ignored in match
// R18: Month alarm comes with day alarm
// R19: Century byte is eight bit value
// R20: Alarm bytes live in bank 0
// R21: Sleep trigger is single-shot command
module sleep_wake_sequencer #(
    parameter int         N_EVENTS   = 4,
    parameter int         OVR_COUNT  = sleep_wake_pkg::OVR_CYCLES,
    parameter logic [5:1] TYPES_SUPP = 5'b11101
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    // Avalon-MM slave
    input  wire logic [4:0]          i_avs_address,
    input  wire logic                i_avs_read,
    input  wire logic                i_avs_write,
    input  wire logic [31:0]         i_avs_writedata,
    input  wire logic [3:0]          i_avs_byteenable,
    output logic      [31:0]         o_avs_readdata,
    output logic                     o_avs_waitrequest,
    // Platform inputs
    input  wire logic                i_power_button,
    input  wire logic                i_clock_interrupt_line,
    input  wire logic                i_battery_low,
    input  wire logic                i_proc_stopped,
    input  wire logic [N_EVENTS-1:0] i_wake_events,
    input  wire logic [7:0]          i_cur_day,
    input  wire logic [7:0]          i_cur_month,
    // Platform outputs
    output logic                     o_proc_stop,
    output logic                     o_rails_low,
    output logic                     o_cpu_reset,
    output logic [2:0]               o_sleep_type,
    output logic                     o_power_button_override
);
    // Legal alarm byte: BCD or binary 1..max
    function automatic logic byte_legal(
        input logic [7:0] v,
        input logic [7:0] bcd_max,
        input logic [7:0] bin_max
    );
        return (v != 8'h00) && (v <= bin_max
            || (v[3:0] <= 4'h9 && v <= bcd_max));
    endfunction
    sleep_wake_pkg::seq_state_t state_r;
    sleep_wake_pkg::seq_state_t state_nxt;
    sleep_wake_pkg::alarm_bytes_t alarm_r;
    logic [2:0]          type_field_r;
    logic [2:0]          cur_type_r;
    logic                trig_r;
    logic                wake_flag_r;
    logic                pwrb_flag_r;
    logic                alarm_flag_r;
    logic                alarm_en_r;
    logic                deep_wake_r;
    logic [N_EVENTS-1:0] event_en_r;
    logic                pwrb_prev_r;
    logic                irq_prev_r;
    logic [31:0]         hold_cnt_r;
    logic                ovr_done_r;
    logic                bus_req;
    logic                wr_go;
    logic                wr_lane0;
    logic [7:0]          wdat;
    logic                pwrb_edge;
    logic                ovr_fire;
    logic                alarm_event;
    logic                day_hit;
    logic                mon_hit;
    logic                alarm_wake;
    logic                any_wake;
    // Bus handshake, one wait cycle
    assign bus_req  = i_avs_read || i_avs_write;
    assign wr_go    = i_avs_write && !o_avs_waitrequest;
    assign wr_lane0 = wr_go && i_avs_byteenable[0];
    assign wdat     = i_avs_writedata[7:0];
    // One low wait cycle per request
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
    end
    // Read data taken as wait drops
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_avs_readdata <= 32'h0;
        else if (i_avs_read && o_avs_waitrequest)
        begin
            o_avs_readdata <= 32'h0;
            if (i_avs_address == sleep_wake_pkg::OFF_CONTROL)
                // Trigger bit always reads zero
                o_avs_readdata[sleep_wake_pkg::CTL_TYPE_LSB +: 3] <= type_field_r;
            else if (i_avs_address == sleep_wake_pkg::OFF_STATUS)
            begin
                // R9: flag hidden without shallow state
                o_avs_readdata[sleep_wake_pkg::STS_WAKE_BIT] <=
                    wake_flag_r && TYPES_SUPP[1];
                o_avs_readdata[sleep_wake_pkg::STS_PWRB_BIT]  <= pwrb_flag_r;
                o_avs_readdata[sleep_wake_pkg::STS_ALARM_BIT] <= alarm_flag_r;
                o_avs_readdata[sleep_wake_pkg::STS_STATE_LSB +: 3] <= state_r;
                o_avs_readdata[sleep_wake_pkg::STS_TYPE_LSB +: 3]  <= cur_type_r;
            end
            else if (i_avs_address == sleep_wake_pkg::OFF_ENABLE)
            begin
                o_avs_readdata[sleep_wake_pkg::EN_ALARM_BIT] <= alarm_en_r;
                o_avs_readdata[sleep_wake_pkg::EN_DEEP_BIT]  <= deep_wake_r;
                o_avs_readdata[sleep_wake_pkg::EN_EVENTS_LSB +: N_EVENTS] <= event_en_r;
            end
            // R18: day and month both present
            else if (i_avs_address == sleep_wake_pkg::OFF_DAY)
                o_avs_readdata[7:0] <= alarm_r.day;
            else if (i_avs_address == sleep_wake_pkg::OFF_MONTH)
                o_avs_readdata[7:0] <= alarm_r.month;
            else if (i_avs_address == sleep_wake_pkg::OFF_CENTURY)
                o_avs_readdata[7:0] <= alarm_r.century;
        end
    end
    // Sleep type and enables
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            type_field_r <= sleep_wake_pkg::TYPE_WORK;
            alarm_en_r   <= 1'b0;
            deep_wake_r  <= 1'b0;
            event_en_r   <= '0;
        end
        else if (wr_lane0 && i_avs_address == sleep_wake_pkg::OFF_CONTROL)
            type_field_r <= wdat[sleep_wake_pkg::CTL_TYPE_LSB +: 3];
        else if (wr_go && i_avs_address == sleep_wake_pkg::OFF_ENABLE)
        begin
            alarm_en_r  <= i_avs_writedata[sleep_wake_pkg::EN_ALARM_BIT];
            deep_wake_r <= i_avs_writedata[sleep_wake_pkg::EN_DEEP_BIT];
            event_en_r  <= i_avs_writedata[sleep_wake_pkg::EN_EVENTS_LSB +: N_EVENTS];
        end
    end
    // R20: bank 0 alarm bytes
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            alarm_r.day     <= sleep_wake_pkg::RST_ALARM_BYTE;
            alarm_r.month   <= sleep_wake_pkg::RST_ALARM_BYTE;
            alarm_r.century <= sleep_wake_pkg::RST_CENTURY;
        end
        else if (wr_lane0)
        begin
            if (i_avs_address == sleep_wake_pkg::OFF_DAY)
                alarm_r.day <= wdat;
            else if (i_avs_address == sleep_wake_pkg::OFF_MONTH)
                alarm_r.month <= wdat;
            // R19: century kept as raw eight bits
            else if (i_avs_address == sleep_wake_pkg::OFF_CENTURY)
                alarm_r.century <= wdat;
        end
    end
    // R21: one-cycle trigger pulse
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            trig_r <= 1'b0;
        else
            trig_r <= wr_lane0 && i_avs_address == sleep_wake_pkg::OFF_CONTROL
                && wdat[sleep_wake_pkg::CTL_TRIG_BIT] && state_r == sleep_wake_pkg::ST_WORK;
    end
    // Edge history, idle low
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            {pwrb_prev_r, irq_prev_r} <= 2'b00;
        else
            {pwrb_prev_r, irq_prev_r} <= {i_power_button, i_clock_interrupt_line};
    end
    assign pwrb_edge = i_power_button && !pwrb_prev_r;
    // R3: hold counter, fires once per press
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            hold_cnt_r <= 32'h0;
            ovr_done_r <= 1'b0;
        end
        else if (!i_power_button)
        begin
            hold_cnt_r <= 32'h0;
            ovr_done_r <= 1'b0;
        end
        else if (ovr_fire)
            ovr_done_r <= 1'b1;
        else if (!ovr_done_r)
            hold_cnt_r <= hold_cnt_r + 32'h1;
    end
    // Held for at least the hold time
    assign ovr_fire = i_power_button && !ovr_done_r && hold_cnt_r >= 32'(OVR_COUNT);
    // R14: alarm from interrupt line edge
    // R15: bits 6 and 7 masked before both uses in the match
    // R16: illegal day byte matches every day
    assign day_hit = !byte_legal(alarm_r.day & sleep_wake_pkg::DAY_FIELD_MASK,
                                 sleep_wake_pkg::DAY_BCD_MAX,
                                 sleep_wake_pkg::DAY_BIN_MAX)
        || (alarm_r.day & sleep_wake_pkg::DAY_FIELD_MASK) == i_cur_day;
    // R17: illegal month byte matches every month
    assign mon_hit = !byte_legal(alarm_r.month, sleep_wake_pkg::MON_BCD_MAX,
                                 sleep_wake_pkg::MON_BIN_MAX)
        || alarm_r.month == i_cur_month;
    assign alarm_event = i_clock_interrupt_line && !irq_prev_r && day_hit && mon_hit;
    // Status flags, W1C, a set beats a clear
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wake_flag_r  <= 1'b0;
            pwrb_flag_r  <= 1'b0;
            alarm_flag_r <= 1'b0;
        end
        else
        begin
            if (wr_lane0 && i_avs_address == sleep_wake_pkg::OFF_STATUS)
            begin
                if (wdat[sleep_wake_pkg::STS_WAKE_BIT])
                    wake_flag_r <= 1'b0;
                if (wdat[sleep_wake_pkg::STS_PWRB_BIT])
                    pwrb_flag_r <= 1'b0;
                if (wdat[sleep_wake_pkg::STS_ALARM_BIT])
                    alarm_flag_r <= 1'b0;
            end
            // R6: flag set as the wake is taken
            if (state_r == sleep_wake_pkg::ST_SLEEP && any_wake)
                wake_flag_r <= 1'b1;
            // R4: override clears the button flag
            if (ovr_fire)
                pwrb_flag_r <= 1'b0;
            else if (pwrb_edge)
                pwrb_flag_r <= 1'b1;
            // R12: set regardless of the wake enable
            if (alarm_event)
                alarm_flag_r <= 1'b1;
        end
    end
    // R11: S4 alarm wake only with the deep flag set
    // R13: flag and enable wake, battery low blocks it
    assign alarm_wake = alarm_flag_r && alarm_en_r && !i_battery_low
        && (cur_type_r <= sleep_wake_pkg::TYPE_S3
            || (cur_type_r == sleep_wake_pkg::TYPE_S4 && deep_wake_r));
    // R5: enabled events, alarm or button press wake
    assign any_wake = alarm_wake || pwrb_edge || |(i_wake_events & event_en_r);
    // Sequencer next state; override beats everything
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sleep_wake_pkg::ST_WORK:
                // R1: trigger starts entry
                if (trig_r)
                    state_nxt = sleep_wake_pkg::ST_ENTER;
            sleep_wake_pkg::ST_ENTER:
                // R6: sleep counts only once processor stopped
                if (i_proc_stopped)
                    state_nxt = (cur_type_r == sleep_wake_pkg::TYPE_S5)
                        ? sleep_wake_pkg::ST_OFF : sleep_wake_pkg::ST_SLEEP;
            sleep_wake_pkg::ST_SLEEP:
                // R5: return to working on wake
                if (any_wake)
                    state_nxt = sleep_wake_pkg::ST_WAKE;
            sleep_wake_pkg::ST_WAKE:
                state_nxt = sleep_wake_pkg::ST_WORK;
            sleep_wake_pkg::ST_OFF:
                if (pwrb_edge && !ovr_fire)
                    state_nxt = sleep_wake_pkg::ST_WAKE;
            default:
                state_nxt = sleep_wake_pkg::ST_WORK;
        endcase
        // R3: unconditional off on override
        if (ovr_fire)
            state_nxt = sleep_wake_pkg::ST_OFF;
    end
    // State register
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_r <= sleep_wake_pkg::ST_WORK;
        else
            state_r <= state_nxt;
    end
    // R1: latch type as entry starts
    // R10: new type only after a wake back to working
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            cur_type_r <= sleep_wake_pkg::TYPE_WORK;
        else if (ovr_fire)
            cur_type_r <= sleep_wake_pkg::TYPE_S5;
        else if (state_r == sleep_wake_pkg::ST_WORK && trig_r)
            cur_type_r <= type_field_r;
        else if (state_r == sleep_wake_pkg::ST_WAKE)
            cur_type_r <= sleep_wake_pkg::TYPE_WORK;
    end
    // Platform controls from the next state
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_proc_stop  <= 1'b0;
            o_rails_low  <= 1'b0;
            o_sleep_type <= sleep_wake_pkg::TYPE_WORK;
        end
        else
        begin
            o_proc_stop <= state_nxt == sleep_wake_pkg::ST_ENTER
                || state_nxt == sleep_wake_pkg::ST_SLEEP
                || state_nxt == sleep_wake_pkg::ST_OFF;
            // Shallow sleep keeps rails so context survives
            o_rails_low <= state_nxt == sleep_wake_pkg::ST_OFF
                || (state_nxt == sleep_wake_pkg::ST_SLEEP
                    && cur_type_r >= sleep_wake_pkg::TYPE_S2);
            o_sleep_type <= (state_nxt == sleep_wake_pkg::ST_OFF)
                ? sleep_wake_pkg::TYPE_S5
                : (state_nxt == sleep_wake_pkg::ST_WORK)
                    ? sleep_wake_pkg::TYPE_WORK : (trig_r ? type_field_r : cur_type_r);
        end
    end
    // R8: reset pulse on deep wake
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_cpu_reset <= 1'b0;
        else
            o_cpu_reset <= state_r == sleep_wake_pkg::ST_WAKE
                && (cur_type_r >= sleep_wake_pkg::TYPE_S2
                    || cur_type_r == sleep_wake_pkg::TYPE_WORK);
    end
    // One-cycle override notice
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_power_button_override <= 1'b0;
        else
            o_power_button_override <= ovr_fire;
    end
endmodule
`default_nettype wire

// ===== sleep_wake_sequencer_rtc_wake_tb_top.sv
// Self-checking bench for the sleep and wake sequencer
`default_nettype none

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("BAD %0t got %h exp %h", $time, got, exp); \
        end \
    end

module sleep_wake_sequencer_rtc_wake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         OVR = 20;
    localparam logic [4:0] CTL = 5'h00;
    localparam logic [4:0] STS = 5'h04;
    localparam logic [4:0] ENA = 5'h08;

    logic        clk = 1'b0;
    logic        nrst, rd, wr, button, irq_line, batt_low, stopped, slow;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, q, d;
    logic        wait_req, proc_stop, rails_low, cpu_reset, override;
    logic [3:0]  events;
    logic [7:0]  cur_day, cur_month;
    logic [2:0]  sleep_type;
    logic [6:0]  c;
    int          fail_count, comparisons, resets, r, n;
    // Address table with reset values
    logic [4:0]  rst_addr [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
    logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h0, 32'hff, 32'hff, 32'h20, 32'h0};
    // Alarm cases: type, enable, deep flag, battery low, wake expected
    logic [6:0]  al_case [7] = '{7'h39, 7'h19, 7'h29, 7'h30, 7'h3a, 7'h48, 7'h4d};
    // Day byte, month byte, current day, current month
    logic [31:0] dm_case [8] = '{32'hc5ff0501, 32'hc5ff0601, 32'h45ff0507, 32'h3fff1109,
                                 32'h00ff0909, 32'hff030904, 32'hff130904, 32'h200b200b};

    always #10 clk = ~clk;

    sleep_wake_sequencer #(.OVR_COUNT(OVR)) i_sleep_wake_sequencer (
        .i_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_power_button(button),
        .i_clock_interrupt_line(irq_line), .i_battery_low(batt_low),
        .i_proc_stopped(stopped), .i_wake_events(events), .i_cur_day(cur_day),
        .i_cur_month(cur_month), .o_proc_stop(proc_stop), .o_rails_low(rails_low),
        .o_cpu_reset(cpu_reset), .o_sleep_type(sleep_type),
        .o_power_button_override(override));

    proc_rail_model i_proc_rail_model (
        .i_clk(clk), .i_nrst(nrst), .i_proc_stop(proc_stop), .i_slow(slow),
        .o_proc_stopped(stopped));

    // Count processor reset pulses
    always @(posedge clk)
    begin
        if (cpu_reset === 1'b1)
            resets++;
    end

    // Expected alarm match
    function automatic logic alarm_hit(input logic [31:0] v);
        logic [7:0] dy;
        dy = v[31:24] & 8'h3f;
        return (dy == 8'h0 || dy > 8'h31 || dy == v[15:8])
            && (v[23:16] == 8'h0 || v[23:16] > 8'h12 || v[23:16] == v[7:0]);
    endfunction

    // One access, held until waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dt);
        int k = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= dt;
        wr    <= w;
        rd    <= !w;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wait_req !== 1'b0 && k < 50);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        `CHK(k < 50, 1'b1)
    endtask

    // Wait for stop level
    task automatic wait_stop(input logic v);
        int k = 0;
        while (proc_stop !== v && k < 200)
        begin
            @(posedge clk);
            k++;
        end
        `CHK(proc_stop, v)
    endtask

    // Twelve cycles cover the slowest halt
    task automatic sleep_to(input logic [2:0] t);
        slow <= 1'($urandom_range(1));
        bus(1'b1, CTL, {27'h0, 1'b1, 1'b0, t});
        repeat (12) @(posedge clk);
        `CHK(sleep_type, t)
        `CHK(rails_low, t >= 3'h2)
    endtask

    // One random wake source
    task automatic wake_evt();
        @(posedge clk);
        events <= 4'h1 << $urandom_range(3);
        @(posedge clk);
        wait_stop(1'b0);
        events <= 4'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end

    initial
    begin
        {nrst, rd, wr, button, irq_line, batt_low, slow} = 7'h0;
        addr = 5'h0;
        wdata = 32'h0;
        events = 4'h0;
        cur_day = 8'h01;
        cur_month = 8'h01;
        void'($urandom(32'h3347));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (rst_addr[i])
        begin
            bus(1'b0, rst_addr[i], 32'h0);
            `CHK(q, rst_val[i])
        end
        for (int i = 3; i < 6; i++)
        begin
            d = $urandom;
            bus(1'b1, rst_addr[i], d);
            bus(1'b0, rst_addr[i], 32'h0);
            `CHK(q, {24'h0, d[7:0]})
            bus(1'b1, rst_addr[i], rst_val[i]);
        end
        bus(1'b1, 5'h18, 32'hffff_ffff);
        bus(1'b0, 5'h18, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b1, ENA, 32'h0000_0f00);
        for (int t = 1; t < 5; t++)
        begin
            sleep_to(3'(t));
            r = resets;
            wake_evt();
            `CHK(resets - r, (t >= 2) ? 1 : 0)
            `CHK(sleep_type, 3'h0)
            bus(1'b0, STS, 32'h0);
            `CHK(q[0], 1'b1)
            bus(1'b1, STS, 32'h7);
        end
        foreach (al_case[i])
        begin
            c = al_case[i];
            bus(1'b1, ENA, {20'h0, 4'hf, 6'h0, c[2], c[3]});
            batt_low <= c[1];
            sleep_to(c[6:4]);
            irq_line <= 1'b1;
            repeat (6) @(posedge clk);
            irq_line <= 1'b0;
            `CHK(proc_stop, !c[0])
            bus(1'b0, STS, 32'h0);
            `CHK(q[2], 1'b1)
            wake_evt();
            bus(1'b1, STS, 32'h7);
            batt_low <= 1'b0;
        end
        foreach (dm_case[i])
        begin
            bus(1'b1, 5'h0c, {24'h0, dm_case[i][31:24]});
            bus(1'b1, 5'h10, {24'h0, dm_case[i][23:16]});
            cur_day   <= dm_case[i][15:8];
            cur_month <= dm_case[i][7:0];
            irq_line  <= 1'b1;
            repeat (3) @(posedge clk);
            irq_line <= 1'b0;
            bus(1'b0, STS, 32'h0);
            `CHK(q[2], alarm_hit(dm_case[i]))
            bus(1'b1, STS, 32'h7);
        end
        button <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (override !== 1'b1 && n < OVR + 20);
        `CHK(n inside {[OVR + 1:OVR + 3]}, 1'b1)
        `CHK(sleep_type, 3'h5)
        button <= 1'b0;
        bus(1'b0, STS, 32'h0);
        `CHK(q[1], 1'b0)
        r = resets;
        button <= 1'b1;
        wait_stop(1'b0);
        button <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(resets - r, 1)
        conclude();
    end
endmodule

`default_nettype wire
